// >>> vrx_cfg.svh
`ifndef VRX_CFG_SVH
`define VRX_CFG_SVH
`define VRX_ADDR_INFO   10'h00e
`define VRX_ADDR_PATH   10'h055
`define VRX_ADDR_REFCLK 10'h067
`define VRX_PATH_RST    8'h36
`define VRX_INFO_RST    8'h00
`define VRX_REF_RST     8'h00
`define VRX_INFO_RW     8'h70
`define VRX_I_NSP   0
`define VRX_I_EAV   1
`define VRX_I_SAV   2
`define VRX_I_LOCK  3
`define VRX_I_FILT  4
`define VRX_I_DD    5
`define VRX_I_VDD   6
`define VRX_P_EXTV  0
`define VRX_P_SYNC  1
`define VRX_P_CLIP  2
`define VRX_P_NRZI  4
`define VRX_P_DSCR  5
`define VRX_R_GATE_N 0
`define VRX_R_XTAL   1
`define VRX_SCR_TA  3
`define VRX_SCR_TB  8
`define VRX_TRS_V   7
`define VRX_TRS_H   6
`define VRX_LSB2    10'h3fc
`define VRX_LSB1    10'h3fe
`define VRX_BAR_W27 12'h0b4
`define VRX_BAR_W36 12'h0f0
`define VRX_BAR_W54 12'h168
`define VRX_BLK_Y   10'h040
`define VRX_BLK_C   10'h200
`define VRX_PLL_Y   10'h110
`define VRX_PLL_C   10'h200
`define VRX_EQ_Y    10'h198
`define VRX_EQ_C    10'h300
`define VRX_BARS_Y  {10'h040,10'h0d4,10'h138,10'h18c,10'h1f0,10'h244,10'h2a8,10'h3ac}
`define VRX_BARS_B  {10'h200,10'h350,10'h168,10'h2b8,10'h148,10'h298,10'h0b0,10'h200}
`define VRX_BARS_R  {10'h200,10'h2d8,10'h350,10'h328,10'h0d8,10'h0b0,10'h228,10'h200}
`endif

// >>> vrx_pkg.sv
package vrx_pkg;
  typedef logic [9:0] vrx_word_t;
  typedef enum logic [1:0] {
    VRX_R27 = 2'b00,
    VRX_R36 = 2'b01,
    VRX_R54 = 2'b10,
    VRX_RHD = 2'b11
  } vrx_rate_t;
  typedef enum logic [1:0] {
    VRX_ST_ADDR = 2'b00,
    VRX_ST_WR   = 2'b01,
    VRX_ST_RD   = 2'b10
  } vrx_port_st_t;
endpackage

// >>> vrx_ctrl.sv
`timescale 1ns/10ps
`include "vrx_cfg.svh"

module vrx_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   arst_n_in,
  input  wire logic [W-1:0]           in_data_in,
  input  wire logic                   in_valid_in,
  output logic                        in_ready_out,
  output logic [W-1:0]                out_data_out,
  output logic                        out_valid_out,
  input  wire logic                   out_ready_in,
  output logic [$clog2(D+1)-1:0]      level_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0]          mem [D];
  logic [AW-1:0]         wr_q;
  logic [AW-1:0]         rd_q;
  logic [$clog2(D+1)-1:0] cnt_q;
  logic                  push;
  logic                  pop;

  generate
    if (D < 2 || (1 << AW) != D) begin : g_bad
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  assign in_ready_out  = (cnt_q != D[$clog2(D+1)-1:0]);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem[rd_q];
  assign level_out     = cnt_q;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module vrx_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int LINE_MAX   = 4095
) (
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [9:0]       cfg_ad_in,
  output logic      [9:0]       cfg_ad_out,
  output logic                  cfg_ad_oe_n_out,
  input  wire logic             cfg_aclk_in,
  input  wire logic             cfg_rd_wr_in,
  input  wire logic             cfg_anc_sel_in,
  input  wire vrx_pkg::vrx_word_t rx_word_in,
  input  wire logic             rx_valid_in,
  output logic                  rx_ready_out,
  output vrx_pkg::vrx_word_t    vid_word_out,
  output logic                  vid_valid_out,
  input  wire logic             vid_ready_in,
  input  wire logic             cdr_locked_in,
  input  wire logic             cdr_phase_ok_in,
  input  wire logic [5:0]       pattern_sel_in,
  input  wire logic             pattern_en_in,
  output logic                  io_port_bit4_out,
  output logic                  pfd_on_out,
  output logic                  bias_out_cv_out,
  output logic                  word_clk_oe_n_out,
  output logic                  ref_osc_use_out,
  output logic                  xtal_amp_on_out
);
  import vrx_pkg::*;
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  generate
    if (FIFO_DEPTH < 4 || LINE_MAX > 4095) begin : g_bad
      $error("need FIFO_DEPTH >= 4 and LINE_MAX < 4096");
    end
  endgenerate

  logic [7:0]   info_q;
  logic [7:0]   path_q;
  logic [1:0]   ref_q;
  vrx_port_st_t port_st_q;
  logic         aclk_d_q;
  logic [9:0]   addr_q;
  logic         aclk_rise;
  logic [7:0]   rd_mux;

  logic         nrzi_prev_q;
  logic [8:0]   hist_q;
  logic         nrzi_prev_d;
  logic [8:0]   hist_d;
  vrx_word_t    dec_w;
  vrx_word_t    pre0_q;
  vrx_word_t    pre1_q;
  vrx_word_t    pre2_q;
  logic         take;
  logic         is_xyz;
  logic         is_eav;
  logic         misplaced;
  logic [11:0]  pos_q;
  logic [11:0]  line_len_q;
  logic [11:0]  sav_pos_q;
  logic         line_ok_q;
  logic         sav_ok_q;
  logic [11:0]  hold_q;
  logic         vblank_q;
  logic         active_q;
  logic [11:0]  act_q;
  logic [11:0]  bar_cnt_q;
  logic [2:0]   bar_q;
  logic [11:0]  bar_w;
  logic         pat_on;
  vrx_rate_t    rate;
  vrx_word_t    pat_w;
  vrx_word_t    out_w;
  vrx_word_t    s_word_q;
  logic         s_valid_q;

  vrx_word_t    f_data;
  logic         f_valid;
  logic         f_ready;
  logic [LW-1:0] f_level;
  logic         f_pop;

  // ---------------- configuration port ----------------
  assign aclk_rise = cfg_aclk_in & ~aclk_d_q;

  always_comb begin
    rd_mux = 8'h00;
    case (cfg_ad_in)
      `VRX_ADDR_INFO:   rd_mux = info_q;
      `VRX_ADDR_PATH:   rd_mux = path_q;
      `VRX_ADDR_REFCLK: rd_mux = {6'h00, ref_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aclk_d_q        <= 1'b0;
      port_st_q       <= VRX_ST_ADDR;
      addr_q          <= 10'h000;
      cfg_ad_out      <= 10'h000;
      cfg_ad_oe_n_out <= 1'b1;
    end else begin
      aclk_d_q <= cfg_aclk_in;
      case (port_st_q)
        VRX_ST_ADDR: begin
          cfg_ad_oe_n_out <= 1'b1;
          if (aclk_rise && !cfg_anc_sel_in) begin
            addr_q <= cfg_ad_in;
            if (cfg_rd_wr_in) begin
              // data is latched at the address edge, so reads are static
              cfg_ad_out      <= {2'b00, rd_mux};
              cfg_ad_oe_n_out <= 1'b0;
              port_st_q       <= VRX_ST_RD;
            end else begin
              port_st_q <= VRX_ST_WR;
            end
          end
        end
        VRX_ST_WR: begin
          if (aclk_rise) begin
            port_st_q <= VRX_ST_ADDR;
          end
        end
        VRX_ST_RD: begin
          if (aclk_rise || !cfg_rd_wr_in) begin
            cfg_ad_oe_n_out <= 1'b1;
            port_st_q       <= VRX_ST_ADDR;
          end
        end
        default: begin
          cfg_ad_oe_n_out <= 1'b1;
          port_st_q       <= VRX_ST_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      path_q <= `VRX_PATH_RST;
      ref_q  <= 2'(`VRX_REF_RST);
    end else if (port_st_q == VRX_ST_WR && aclk_rise) begin
      if (addr_q == `VRX_ADDR_PATH) begin
        path_q <= cfg_ad_in[7:0];
      end
      if (addr_q == `VRX_ADDR_REFCLK) begin
        ref_q <= cfg_ad_in[1:0];
      end
    end
  end

  // status bits in the same register are owned by the stream logic and the lock inputs
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      info_q <= `VRX_INFO_RST;
    end else begin
      if (port_st_q == VRX_ST_WR && aclk_rise &&
          addr_q == `VRX_ADDR_INFO) begin
        info_q[`VRX_I_FILT] <= cfg_ad_in[`VRX_I_FILT];
        info_q[`VRX_I_DD]   <= cfg_ad_in[`VRX_I_DD];
        info_q[`VRX_I_VDD]  <= cfg_ad_in[`VRX_I_VDD];
      end
      info_q[`VRX_I_LOCK] <= cdr_locked_in & cdr_phase_ok_in;
      if (take && is_xyz) begin
        info_q[`VRX_I_EAV] <= is_eav;
        info_q[`VRX_I_SAV] <= ~is_eav;
      end
      // set beats clear when a misplaced EAV both arrives and would clear
      if (take && is_xyz && misplaced) begin
        info_q[`VRX_I_NSP] <= 1'b1;
      end else if (take && is_xyz && is_eav && hold_q == 12'h000) begin
        info_q[`VRX_I_NSP] <= 1'b0;
      end
    end
  end

  // ---------------- clock and pin options ----------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io_port_bit4_out  <= 1'b0;
      pfd_on_out        <= 1'b0;
      bias_out_cv_out   <= 1'b0;
      word_clk_oe_n_out <= 1'b0;
      ref_osc_use_out   <= 1'b1;
      xtal_amp_on_out   <= 1'b0;
    end else begin
      io_port_bit4_out  <= cdr_locked_in & cdr_phase_ok_in;
      pfd_on_out        <= path_q[`VRX_P_EXTV];
      bias_out_cv_out   <= path_q[`VRX_P_EXTV];
      word_clk_oe_n_out <= path_q[`VRX_P_EXTV];
      ref_osc_use_out   <= ~ref_q[`VRX_R_GATE_N];
      xtal_amp_on_out   <= ref_q[`VRX_R_XTAL];
    end
  end

  // ---------------- serial decode, LSB first ----------------
  always_comb begin
    logic b;
    logic n;
    b = 1'b0;
    n = 1'b0;
    nrzi_prev_d = nrzi_prev_q;
    hist_d      = hist_q;
    dec_w       = '0;
    for (int i = 0; i < 10; i++) begin
      b = rx_word_in[i];
      n = path_q[`VRX_P_NRZI] ? (b ^ nrzi_prev_d) : b;
      nrzi_prev_d = b;
      dec_w[i] = path_q[`VRX_P_DSCR] ?
                 (n ^ hist_d[`VRX_SCR_TA] ^ hist_d[`VRX_SCR_TB]) : n;
      hist_d = {hist_d[7:0], n};
    end
  end

  assign take   = rx_valid_in & rx_ready_out;
  assign is_xyz = path_q[`VRX_P_SYNC] && dec_w[9] &&
                  ((pre2_q & `VRX_LSB2) == `VRX_LSB2) &&
                  pre1_q == '0 && pre0_q == '0;
  assign is_eav = dec_w[`VRX_TRS_H];
  assign misplaced = is_eav ? (!line_ok_q || pos_q != line_len_q)
                            : (!sav_ok_q || pos_q != sav_pos_q);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nrzi_prev_q <= 1'b0;
      hist_q      <= 9'h000;
      pre0_q      <= '0;
      pre1_q      <= '0;
      pre2_q      <= '0;
    end else if (take) begin
      nrzi_prev_q <= nrzi_prev_d;
      hist_q      <= hist_d;
      pre0_q      <= dec_w;
      pre1_q      <= pre0_q;
      pre2_q      <= pre1_q;
    end
  end

  // ---------------- line timing and sync position ----------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pos_q      <= 12'h000;
      line_len_q <= 12'h000;
      sav_pos_q  <= 12'h000;
      line_ok_q  <= 1'b0;
      sav_ok_q   <= 1'b0;
      hold_q     <= 12'h000;
      vblank_q   <= 1'b0;
      active_q   <= 1'b0;
    end else if (take) begin
      pos_q <= (pos_q == LINE_MAX[11:0]) ? pos_q : pos_q + 1'b1;
      if (hold_q != 12'h000) begin
        hold_q <= hold_q - 1'b1;
      end
      if (is_xyz) begin
        vblank_q <= dec_w[`VRX_TRS_V];
        active_q <= ~is_eav;
        if (is_eav) begin
          line_len_q <= pos_q;
          line_ok_q  <= 1'b1;
          pos_q      <= 12'h000;
        end else begin
          sav_pos_q <= pos_q;
          sav_ok_q  <= 1'b1;
        end
        // a retrigger restarts the one-line hold
        if (misplaced) begin
          hold_q <= line_ok_q ? line_len_q : LINE_MAX[11:0];
        end
      end
    end
  end

  // ---------------- pattern generator ----------------
  assign rate = vrx_rate_t'(pattern_sel_in[3:2]);

  // HD codes and the unused SD rate field generate no pattern
  always_comb begin
    pat_on = pattern_en_in & ~pattern_sel_in[5];
    bar_w  = `VRX_BAR_W27;
    case (rate)
      VRX_R27: bar_w = `VRX_BAR_W27;
      VRX_R36: bar_w = `VRX_BAR_W36;
      VRX_R54: bar_w = `VRX_BAR_W54;
      default: pat_on = 1'b0;
    endcase
  end

  function automatic vrx_word_t bar_val(input logic [2:0] idx,
                                        input logic [1:0] comp);
    logic [79:0] t;
    t = (comp == 2'b00) ? `VRX_BARS_Y :
        (comp == 2'b01) ? `VRX_BARS_B : `VRX_BARS_R;
    return t[idx*10 +: 10];
  endfunction

  always_comb begin
    logic [1:0]  comp;
    logic [10:0] avg;
    comp = act_q[0] ? 2'b00 : (act_q[1] ? 2'b10 : 2'b01);
    avg  = 11'h000;
    case (pattern_sel_in[1:0])
      2'b00: pat_w = act_q[0] ? `VRX_BLK_Y : `VRX_BLK_C;
      2'b01: pat_w = act_q[0] ? `VRX_PLL_Y : `VRX_PLL_C;
      2'b10: pat_w = act_q[0] ? `VRX_EQ_Y : `VRX_EQ_C;
      default: begin
        pat_w = bar_val(bar_q, comp);
        // halfway code softens the step for downstream converters
        if (info_q[`VRX_I_FILT] && bar_cnt_q == 12'h000 &&
            bar_q != 3'h0) begin
          avg = {1'b0, bar_val(bar_q - 3'h1, comp)} +
                {1'b0, bar_val(bar_q, comp)};
          pat_w = avg[10:1];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_q     <= 12'h000;
      bar_cnt_q <= 12'h000;
      bar_q     <= 3'h0;
    end else if (take) begin
      if (is_xyz) begin
        act_q     <= 12'h000;
        bar_cnt_q <= 12'h000;
        bar_q     <= 3'h0;
      end else if (active_q) begin
        act_q <= act_q + 1'b1;
        if (bar_cnt_q == bar_w - 1'b1) begin
          bar_cnt_q <= 12'h000;
          bar_q     <= (bar_q == 3'h7) ? bar_q : bar_q + 1'b1;
        end else begin
          bar_cnt_q <= bar_cnt_q + 1'b1;
        end
      end
    end
  end

  // ---------------- word selection, clip, de-dither ----------------
  always_comb begin
    out_w = dec_w;
    if (path_q[`VRX_P_CLIP] && (is_xyz ||
        (dec_w & `VRX_LSB2) == `VRX_LSB2)) begin
      out_w = dec_w & `VRX_LSB2;
    end else if (active_q && pat_on) begin
      out_w = pat_w;
    end else if (info_q[`VRX_I_DD] &&
                 (!vblank_q || info_q[`VRX_I_VDD])) begin
      out_w = dec_w & `VRX_LSB1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_word_q  <= '0;
      s_valid_q <= 1'b0;
    end else begin
      s_valid_q <= take;
      if (take) begin
        s_word_q <= out_w;
      end
    end
  end

  // ---------------- output buffering ----------------
  vrx_fifo #(
    .W (10),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .in_data_in    (s_word_q),
    .in_valid_in   (s_valid_q),
    .in_ready_out  (f_ready),
    .out_data_out  (f_data),
    .out_valid_out (f_valid),
    .out_ready_in  (~vid_valid_out | vid_ready_in),
    .level_out     (f_level)
  );

  assign f_pop = f_valid & (~vid_valid_out | vid_ready_in);

  // ready looks two words ahead: one in the stage, one being taken now
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_ready_out  <= 1'b0;
      vid_valid_out <= 1'b0;
      vid_word_out  <= '0;
    end else begin
      rx_ready_out <= ({1'b0, f_level} + LW'(s_valid_q) + LW'(take) +
                       LW'(1)) <= (LW + 1)'(FIFO_DEPTH);
      if (f_pop) begin
        vid_word_out  <= f_data;
        vid_valid_out <= 1'b1;
      end else if (vid_ready_in) begin
        vid_valid_out <= 1'b0;
      end
    end
  end
endmodule

// >>> vrx_ctrl_assertions.sv
`timescale 1ns/10ps
module vrx_ctrl_checker #(
  parameter int FIFO_DEPTH = 8,
  parameter int LINE_MAX   = 4095
) (
  input wire logic               ref_clk_in,
  input wire logic               arst_n_in,
  input wire logic [9:0]         cfg_ad_in,
  input wire logic [9:0]         cfg_ad_out,
  input wire logic               cfg_ad_oe_n_out,
  input wire logic               cfg_aclk_in,
  input wire logic               cfg_rd_wr_in,
  input wire logic               cfg_anc_sel_in,
  input wire vrx_pkg::vrx_word_t vid_word_out,
  input wire logic               vid_valid_out,
  input wire logic               vid_ready_in,
  input wire logic               cdr_locked_in,
  input wire logic               cdr_phase_ok_in,
  input wire logic               io_port_bit4_out,
  input wire logic               pfd_on_out,
  input wire logic               bias_out_cv_out,
  input wire logic               word_clk_oe_n_out,
  input wire logic               ref_osc_use_out,
  input wire logic               xtal_amp_on_out
);
  import vrx_pkg::*;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_lock_follow: assert property (
    io_port_bit4_out == $past(cdr_locked_in && cdr_phase_ok_in))
    else $error("lock output does not follow recovery state");
  a_read_answer: assert property (
    ($rose(cfg_aclk_in) && cfg_rd_wr_in && !cfg_anc_sel_in && cfg_ad_oe_n_out
     && cfg_ad_in == 10'h00e) |=> !cfg_ad_oe_n_out [*2])
    else $error("status read not answered");
  a_refclk_zero: assert property (
    ($rose(cfg_aclk_in) && cfg_rd_wr_in && !cfg_anc_sel_in && cfg_ad_oe_n_out
     && cfg_ad_in == 10'h067) |=> cfg_ad_out[9:2] == 8'h00)
    else $error("unused reference bits not zero");
  a_unmapped_zero: assert property (
    ($rose(cfg_aclk_in) && cfg_rd_wr_in && !cfg_anc_sel_in && cfg_ad_oe_n_out
     && !(cfg_ad_in inside {10'h00e, 10'h055, 10'h067}))
    |=> cfg_ad_out == 10'h000)
    else $error("unmapped read not zero");
  a_anc_ignored: assert property (
    ($rose(cfg_aclk_in) && cfg_anc_sel_in && cfg_ad_oe_n_out)
    |=> cfg_ad_oe_n_out [*3])
    else $error("ancillary access answered");
  a_read_release: assert property (
    ($fell(cfg_rd_wr_in) && !cfg_ad_oe_n_out) |-> ##[1:2] cfg_ad_oe_n_out)
    else $error("read data not released");
  a_vcxo_pair: assert property (
    pfd_on_out == bias_out_cv_out && word_clk_oe_n_out == pfd_on_out)
    else $error("vcxo outputs disagree");
  a_ref_cause: assert property (
    ($changed(ref_osc_use_out) || $changed(xtal_amp_on_out))
    |-> ($past(cfg_aclk_in, 2) || $past(cfg_aclk_in, 3)
         || $past(cfg_aclk_in, 4)))
    else $error("reference control changed without a write");
  a_stream_hold: assert property (
    (vid_valid_out && !vid_ready_in) |=> (vid_valid_out && $stable(vid_word_out)))
    else $error("output word dropped while stalled");
endmodule

// >>> vrx_host_model.sv
`timescale 1ns/10ps
// host on the config port; it only strobes writes and reads, and the
// testbench sets the reference bits and the path default back after tests
module vrx_host_model (
  input  wire logic       clk_in,
  input  wire logic [9:0] dev_ad_in,
  input  wire logic       dev_oe_n_in,
  output logic      [9:0] ad_out,
  output logic            aclk_out,
  output logic            rd_wr_out,
  output logic            anc_sel_out
);
  initial begin
    ad_out = 10'h000;
    aclk_out = 1'b0;
    rd_wr_out = 1'b0;
    anc_sel_out = 1'b0;
  end
  // strobe low for a full cycle between rises
  task automatic strobe(input logic [9:0] v, input logic rw, input logic anc);
    @(posedge clk_in);
    #1;
    ad_out = v;
    rd_wr_out = rw;
    anc_sel_out = anc;
    aclk_out = 1'b1;
    @(posedge clk_in);
    #1;
    aclk_out = 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    strobe(a, 1'b0, 1'b0);
    strobe({2'b00, d}, 1'b0, 1'b0);
    ad_out = ~ad_out;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // released bus shows the inverse so stale data never looks valid
  task automatic rd(input logic [9:0] a, input logic anc, output logic [9:0] d);
    int n;
    n = 0;
    strobe(a, 1'b1, anc);
    ad_out = ~ad_out;
    do begin
      @(posedge clk_in);
      n++;
    end while (dev_oe_n_in && n < 4);
    d = dev_ad_in;
    #1;
    rd_wr_out = 1'b0;
    anc_sel_out = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
endmodule

// >>> tb_video_rx_control_status.sv
`timescale 1ns/10ps
`define CHK(g, e) check_val(10'(g), 10'(e))
module tb_video_rx_control_status;
  import vrx_pkg::*;
  localparam int FIFO_DEPTH = 8;
  localparam int LINE_MAX   = 64;
  localparam logic [9:0] RA [4] = '{10'h00e, 10'h055, 10'h067, 10'h100};
  localparam logic [9:0] RE [4] = '{10'h000, 10'h036, 10'h000, 10'h000};
  localparam logic [7:0] DM [3] = '{8'h00, 8'h20, 8'h60};
  logic       ref_clk_in, arst_n_in, rx_valid_in, rx_ready_out, vid_valid_out;
  logic       vid_ready_in, cdr_locked_in, cdr_phase_ok_in, io_port_bit4_out;
  logic       pfd_on_out, bias_out_cv_out, word_clk_oe_n_out, ref_osc_use_out;
  logic       xtal_amp_on_out, cfg_ad_oe_n_out, aclk, rd_wr, anc;
  logic       stall, dd, vdd, vb, ok;
  logic [9:0] host_ad, ad_wire, cfg_ad_out, got, h1, h2, h3;
  vrx_word_t  rx_word_in, vid_word_out;
  int         errors, total_checks, cycles, acc, ai;
  logic       pe = 1'b0, act = 1'b0;
  logic [9:0] expq [$];

  // the device drives the shared bus only while its enable is low
  assign ad_wire = cfg_ad_oe_n_out ? host_ad : cfg_ad_out;
  vrx_host_model host (.clk_in(ref_clk_in), .dev_ad_in(ad_wire),
    .dev_oe_n_in(cfg_ad_oe_n_out), .ad_out(host_ad), .aclk_out(aclk),
    .rd_wr_out(rd_wr), .anc_sel_out(anc));
  vrx_ctrl #(.FIFO_DEPTH(FIFO_DEPTH), .LINE_MAX(LINE_MAX)) dut (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .cfg_ad_in(ad_wire),
    .cfg_ad_out(cfg_ad_out), .cfg_ad_oe_n_out(cfg_ad_oe_n_out),
    .cfg_aclk_in(aclk), .cfg_rd_wr_in(rd_wr), .cfg_anc_sel_in(anc),
    .rx_word_in(rx_word_in), .rx_valid_in(rx_valid_in),
    .rx_ready_out(rx_ready_out), .vid_word_out(vid_word_out),
    .vid_valid_out(vid_valid_out), .vid_ready_in(vid_ready_in),
    .cdr_locked_in(cdr_locked_in), .cdr_phase_ok_in(cdr_phase_ok_in),
    .pattern_sel_in(6'h00), .pattern_en_in(pe),
    .io_port_bit4_out(io_port_bit4_out), .pfd_on_out(pfd_on_out),
    .bias_out_cv_out(bias_out_cv_out), .word_clk_oe_n_out(word_clk_oe_n_out),
    .ref_osc_use_out(ref_osc_use_out), .xtal_amp_on_out(xtal_amp_on_out));

  task automatic check_val(input logic [9:0] g, input logic [9:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // clip on sync words and the top codes, then optional lsb de-dither
  function automatic logic [9:0] exp_word(input logic [9:0] w, input logic t);
    logic [9:0] e;
    e = (t || w >= 10'h3fc) ? (w & 10'h3fc) : w;
    if (!t && dd && (!vb || vdd))
      e[0] = 1'b0;
    return e;
  endfunction
  task automatic put(input logic [9:0] w, input int lim);
    int n;
    logic t;
    logic [9:0] e;
    n = 0;
    t = (h3 == 10'h3ff && h2 == 10'h000 && h1 == 10'h000);
    e = exp_word(w, t);
    if (!t && act && pe && w < 10'h3fc)
      e = ai[0] ? 10'h040 : 10'h200;
    rx_word_in = w;
    rx_valid_in = 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (!rx_ready_out && n < lim);
    ok = rx_ready_out;
    if (ok) begin
      expq.push_back(e);
      if (t) begin
        vb = w[7];
        act = !w[6];
        ai = 0;
      end else if (act) begin
        ai++;
      end
      h3 = h2;
      h2 = h1;
      h1 = w;
    end
    #1;
  endtask
  task automatic idle();
    rx_valid_in = 1'b0;
    rx_word_in = ~rx_word_in;
  endtask
  task automatic trs(input logic [9:0] xyz);
    put(10'h3ff, 50);
    put(10'h000, 50);
    put(10'h000, 50);
    put(xyz, 50);
    idle();
  endtask
  task automatic burst(input int n);
    repeat (n) put(10'($urandom_range(1019, 0)), 50);
    idle();
  endtask
  task automatic drain();
    for (int n = 0; n < 400 && expq.size() > 0; n++)
      @(posedge ref_clk_in);
    #1;
    `CHK(expq.size(), 0);
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always begin
    @(posedge ref_clk_in);
    #1;
    vid_ready_in = !stall && ($urandom % 4 != 0);
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  always @(posedge ref_clk_in)
    if (arst_n_in && vid_valid_out && vid_ready_in)
      `CHK(vid_word_out, (expq.size() > 0) ? expq.pop_front() : 10'bx);

  initial begin
    void'($urandom(42));
    {arst_n_in, rx_valid_in, cdr_locked_in, cdr_phase_ok_in} = 4'h0;
    {stall, dd, vdd, vb, vid_ready_in} = 5'h00;
    {rx_word_in, h1, h2, h3} = 40'h0;
    repeat (10) @(posedge ref_clk_in);
    #1;
    arst_n_in = 1'b1;
    `CHK({ref_osc_use_out, xtal_amp_on_out}, 2'b10);
    `CHK({pfd_on_out, word_clk_oe_n_out}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      host.rd(RA[i], 1'b0, got);
      `CHK(got, RE[i]);
    end
    host.wr(10'h067, 8'hff);
    host.rd(10'h067, 1'b0, got);
    `CHK(got, 10'h003);
    `CHK({ref_osc_use_out, xtal_amp_on_out}, 2'b01);
    host.wr(10'h067, 8'h00);
    `CHK(ref_osc_use_out, 1'b1);
    host.wr(10'h00e, 8'hff);
    host.rd(10'h00e, 1'b0, got);
    `CHK(got, 10'h070);
    host.wr(10'h00e, 8'h00);
    host.wr(10'h055, 8'h37);
    `CHK({pfd_on_out, bias_out_cv_out, word_clk_oe_n_out}, 3'b111);
    host.wr(10'h100, 8'haa);
    host.rd(10'h055, 1'b0, got);
    `CHK(got, 10'h037);
    host.rd(10'h00e, 1'b1, got);
    `CHK(cfg_ad_oe_n_out, 1'b1);
    host.wr(10'h055, 8'h06);
    `CHK(pfd_on_out, 1'b0);
    for (int k = 0; k < 4; k++) begin
      {cdr_phase_ok_in, cdr_locked_in} = 2'(k);
      host.rd(10'h00e, 1'b0, got);
      `CHK({io_port_bit4_out, got[3]}, {2{k == 3}});
    end
    trs(10'h200);
    host.rd(10'h00e, 1'b0, got);
    `CHK(got[2:0], 3'b101);
    put(10'h3fd, 50);
    put(10'h3fe, 50);
    burst(30);
    trs(10'h274);
    host.rd(10'h00e, 1'b0, got);
    `CHK(got[2:1], 2'b01);
    for (int v = 0; v < 2; v++) begin
      for (int m = 0; m < 3; m++) begin
        host.wr(10'h00e, DM[m]);
        host.rd(10'h00e, 1'b0, got);
        `CHK(got[6:4], DM[m][6:4]);
        dd = (m > 0);
        vdd = (m == 2);
        trs((v == 1) ? 10'h2b0 : 10'h200);
        burst(8);
        drain();
      end
    end
    pe = 1'b1;
    trs(10'h200);
    burst(8);
    drain();
    pe = 1'b0;
    host.wr(10'h00e, 8'h00);
    dd = 1'b0;
    stall = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    ok = 1'b1;
    acc = 0;
    for (int i = 0; i < 20 && ok; i++) begin
      put(10'($urandom_range(1019, 0)), 6);
      acc += ok;
    end
    idle();
    `CHK({acc >= FIFO_DEPTH, acc < 20}, 2'b11);
    stall = 1'b0;
    drain();
    host.wr(10'h055, 8'h36);
    host.rd(10'h055, 1'b0, got);
    `CHK(got, 10'h036);
    end_sim();
  end
endmodule

bind vrx_ctrl vrx_ctrl_checker #(.FIFO_DEPTH(FIFO_DEPTH), .LINE_MAX(LINE_MAX))
  u_chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .cfg_ad_in(cfg_ad_in), .cfg_ad_out(cfg_ad_out),
  .cfg_ad_oe_n_out(cfg_ad_oe_n_out), .cfg_aclk_in(cfg_aclk_in),
  .cfg_rd_wr_in(cfg_rd_wr_in), .cfg_anc_sel_in(cfg_anc_sel_in),
  .vid_word_out(vid_word_out), .vid_valid_out(vid_valid_out),
  .vid_ready_in(vid_ready_in), .cdr_locked_in(cdr_locked_in),
  .cdr_phase_ok_in(cdr_phase_ok_in), .io_port_bit4_out(io_port_bit4_out),
  .pfd_on_out(pfd_on_out), .bias_out_cv_out(bias_out_cv_out),
  .word_clk_oe_n_out(word_clk_oe_n_out), .ref_osc_use_out(ref_osc_use_out),
  .xtal_amp_on_out(xtal_amp_on_out));
